/* verilog/adc_seq_defs.svh */
// Constants for the dual-slope sequencer and its host end
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define CORE_MHZ      100
`define SYS_DIV       4
`define INIT_CYCLES   8
`define COUNT_BITS    23
`define RESULT_BITS   24
`define TIMEOUT_US    5500
`define IZERO_US      2000
`define SCLK_LOW_US   11
`define INTEG_US_0    16667
`define INTEG_US_1    33333
`define INTEG_US_2    50000
`define INTEG_US_3    66667
`define INTEG_US_4    100000
`define INTEG_US_5    166667
`define INTEG_US_6    200000
`define INTEG_US_7    300000
`define INTEG_SEL_DEF 3'h4
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_RESULT    8'h08
`define CTRL_PDOWN    0
`define CTRL_SELECT   1
`define CTRL_SEL_LSB  2
`define CTRL_RESET    32'h00000012
`define STAT_VALID    0
`define STAT_BUSY     1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* verilog/adc_seq_pkg.sv */
// Types shared by the sequencer and its host end
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_INIT  = 3'b000,
    ST_AZERO = 3'b001,
    ST_SEND  = 3'b010,
    ST_INTEG = 3'b011,
    ST_DEINT = 3'b100,
    ST_IZERO = 3'b101,
    ST_PDOWN = 3'b110
  } seq_state_t;
  typedef enum logic [1:0] {
    PH_AZERO = 2'b00,
    PH_INTEG = 2'b01,
    PH_DEINT = 2'b10,
    PH_IZERO = 2'b11
  } phase_t;
  typedef enum logic [1:0] {
    HS_IDLE      = 2'b00,
    HS_CLK_LOW   = 2'b01,
    HS_WAIT_HIGH = 2'b10
  } host_state_t;
endpackage : adc_seq_pkg

/* verilog/adc_link_if.sv */
// Serial result link between sequencer and host
`timescale 1ns/1ps
interface adc_link_if;
  logic       csN;
  logic       powerRunN;
  logic [2:0] integSel;
  logic       readyN;
  logic       readyOe;
  logic       dout;
  logic       doutOe;
  logic       sclkOut;
  logic       sclkOe;
  logic       readyLine;
  logic       doutLine;
  logic       sclkLine;
  // Undriven lines rest high through pull-ups
  assign readyLine = readyOe ? readyN : 1'b1;
  assign doutLine  = doutOe ? dout : 1'b1;
  assign sclkLine  = sclkOe ? sclkOut : 1'b1;
  modport dev (
    input  csN, powerRunN, integSel, sclkLine,
    output readyN, readyOe, dout, doutOe
  );
  modport host (
    output csN, powerRunN, integSel, sclkOut, sclkOe,
    input  readyLine, doutLine
  );
endinterface : adc_link_if

/* verilog/tick_divider.sv */
// System tick generator dividing the core clock
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module tick_divider #(
  parameter int unsigned DIV = `SYS_DIV
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic run,
  output logic      tick
);
  logic [$clog2(DIV)-1:0] cnt_reg;
  logic                   tick_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn || !run) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == ($clog2(DIV))'(DIV - 1));
      if (cnt_reg == ($clog2(DIV))'(DIV - 1))
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = tick_reg;
endmodule : tick_divider

/* verilog/adc_sequencer.sv */
// Dual-slope converter sequencer, device end of the result link
// How it works
// - Cycle auto zero, integrate, deintegrate, integrator zero
// - System tick is core clock over four
// - Ready low only in auto zero with result
// - Init clears everything, then power input sampled
// - Power input low runs, high powers down
// - Power-down idles analog side, stops oscillator
// - Power input low again restarts and converts
// - Link takes part only while select low
// - Deselected: ready, data, clock lines released
// - Host selects one device per conversion
// - Host holds select a full cycle first
// - Three select inputs pick integration period
// - Host defaults integration period to 100 ms
// - Comparator falls at zero crossing in deintegrate
// - Send 23 count bits MSB first, then sign
// - Bit shown with ready low, host pulses clock
// - No clock in 5.5 ms: time out, convert
// - Two phase outputs, one comparator input
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sequencer #(
  parameter int unsigned TICKS_PER_US  = `CORE_MHZ / `SYS_DIV,
  parameter int unsigned TIMEOUT_TICKS = `TIMEOUT_US * TICKS_PER_US,
  parameter int unsigned IZERO_TICKS   = `IZERO_US * TICKS_PER_US,
  parameter int unsigned INTEG_DIV     = 1
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  output logic [1:0]      phaseCtl,
  input  wire logic       comparator,
  output logic            analogLowPower,
  output logic            oscRun,
  adc_link_if.dev         link
);
  localparam int unsigned INTEG_US [8] = '{
    `INTEG_US_0, `INTEG_US_1, `INTEG_US_2, `INTEG_US_3,
    `INTEG_US_4, `INTEG_US_5, `INTEG_US_6, `INTEG_US_7
  };
  localparam logic [`COUNT_BITS-1:0] COUNT_MAX = '1;
  localparam logic [4:0] LAST_BIT = 5'(`RESULT_BITS - 1);

  adc_seq_pkg::seq_state_t       state_reg;
  adc_seq_pkg::phase_t           phaseCtl_reg;
  logic [31:0]                   timer_reg;
  logic [31:0]                   integTarget;
  logic [`COUNT_BITS-1:0]        count_reg;
  logic                          sign_reg;
  logic                          haveResult_reg;
  logic [`RESULT_BITS-1:0]       shift_reg;
  logic [4:0]                    bitIdx_reg;
  logic                          sclkLow_reg;
  logic                          gap_reg;
  logic                          readyN_reg;
  logic                          readyOe_reg;
  logic                          doutOe_reg;
  logic                          lowPower_reg;
  logic                          oscRun_reg;
  logic                          tick;
  logic                          selected;
  logic                          sclkRise;

  // System tick from the oscillator clock
  tick_divider #(
    .DIV (`SYS_DIV)
  ) uTick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .run      (oscRun_reg),
    .tick     (tick)
  );

  // Period scaled down only for short runs
  assign integTarget = 32'(INTEG_US[link.integSel] * TICKS_PER_US /
                           INTEG_DIV);
  assign selected    = !link.csN;
  assign sclkRise    = selected && sclkLow_reg && link.sclkLine;

  // Conversion sequencing and result transfer
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg      <= adc_seq_pkg::ST_INIT;
      timer_reg      <= '0;
      count_reg      <= '0;
      sign_reg       <= 1'b0;
      haveResult_reg <= 1'b0;
      shift_reg      <= '0;
      bitIdx_reg     <= '0;
      sclkLow_reg    <= 1'b0;
      gap_reg        <= 1'b0;
      readyN_reg     <= 1'b1;
    end else if (state_reg != adc_seq_pkg::ST_INIT &&
                 state_reg != adc_seq_pkg::ST_PDOWN &&
                 link.powerRunN) begin
      state_reg      <= adc_seq_pkg::ST_PDOWN;
      haveResult_reg <= 1'b0;
      readyN_reg     <= 1'b1;
      timer_reg      <= '0;
    end else begin
      case (state_reg)
        adc_seq_pkg::ST_INIT: begin
          if (timer_reg == 32'(`INIT_CYCLES - 1)) begin
            timer_reg <= '0;
            if (link.powerRunN)
              state_reg <= adc_seq_pkg::ST_PDOWN;
            else
              state_reg <= adc_seq_pkg::ST_AZERO;
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        adc_seq_pkg::ST_PDOWN: begin
          if (!link.powerRunN) begin
            state_reg <= adc_seq_pkg::ST_AZERO;
            timer_reg <= '0;
          end
        end
        adc_seq_pkg::ST_AZERO: begin
          if (haveResult_reg) begin
            state_reg   <= adc_seq_pkg::ST_SEND;
            shift_reg   <= {count_reg, sign_reg};
            readyN_reg  <= 1'b0;
            timer_reg   <= '0;
            bitIdx_reg  <= '0;
            sclkLow_reg <= 1'b0;
            gap_reg     <= 1'b0;
          end else if (tick) begin
            if (timer_reg >= integTarget - 32'h1) begin
              state_reg <= adc_seq_pkg::ST_INTEG;
              timer_reg <= '0;
            end else begin
              timer_reg <= timer_reg + 32'h1;
            end
          end
        end
        adc_seq_pkg::ST_SEND: begin
          if (gap_reg) begin
            gap_reg    <= 1'b0;
            readyN_reg <= 1'b0;
          end else if (sclkRise) begin
            readyN_reg  <= 1'b1;
            sclkLow_reg <= 1'b0;
            shift_reg   <= {shift_reg[`RESULT_BITS-2:0], 1'b0};
            bitIdx_reg  <= bitIdx_reg + 5'h1;
            if (bitIdx_reg == LAST_BIT) begin
              state_reg      <= adc_seq_pkg::ST_INTEG;
              haveResult_reg <= 1'b0;
              timer_reg      <= '0;
            end else begin
              gap_reg <= 1'b1;
            end
          end else begin
            if (selected && !link.sclkLine)
              sclkLow_reg <= 1'b1;
            if (bitIdx_reg == 5'h0 && !sclkLow_reg && tick) begin
              if (timer_reg >= 32'(TIMEOUT_TICKS - 1)) begin
                readyN_reg     <= 1'b1;
                state_reg      <= adc_seq_pkg::ST_INTEG;
                haveResult_reg <= 1'b0;
                timer_reg      <= '0;
              end else begin
                timer_reg <= timer_reg + 32'h1;
              end
            end
          end
        end
        adc_seq_pkg::ST_INTEG: begin
          if (tick) begin
            if (timer_reg >= integTarget - 32'h1) begin
              state_reg <= adc_seq_pkg::ST_DEINT;
              sign_reg  <= comparator;
              count_reg <= '0;
              timer_reg <= '0;
            end else begin
              timer_reg <= timer_reg + 32'h1;
            end
          end
        end
        adc_seq_pkg::ST_DEINT: begin
          if (!comparator) begin
            state_reg      <= adc_seq_pkg::ST_IZERO;
            haveResult_reg <= 1'b1;
          end else if (tick) begin
            if (count_reg == COUNT_MAX) begin
              state_reg      <= adc_seq_pkg::ST_IZERO;
              haveResult_reg <= 1'b1;
            end else begin
              count_reg <= count_reg + 1'b1;
            end
          end
        end
        adc_seq_pkg::ST_IZERO: begin
          if (tick) begin
            if (timer_reg >= 32'(IZERO_TICKS - 1)) begin
              state_reg <= adc_seq_pkg::ST_AZERO;
              timer_reg <= '0;
            end else begin
              timer_reg <= timer_reg + 32'h1;
            end
          end
        end
        default: begin
          state_reg <= adc_seq_pkg::ST_INIT;
          timer_reg <= '0;
        end
      endcase
    end
  end

  // Phase control to the analog processor
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phaseCtl_reg <= adc_seq_pkg::PH_AZERO;
    end else begin
      case (state_reg)
        adc_seq_pkg::ST_INTEG: phaseCtl_reg <= adc_seq_pkg::PH_INTEG;
        adc_seq_pkg::ST_DEINT: phaseCtl_reg <= adc_seq_pkg::PH_DEINT;
        adc_seq_pkg::ST_IZERO: phaseCtl_reg <= adc_seq_pkg::PH_IZERO;
        default:               phaseCtl_reg <= adc_seq_pkg::PH_AZERO;
      endcase
    end
  end

  // Power-down of analog side and oscillator
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lowPower_reg <= 1'b0;
      oscRun_reg   <= 1'b1;
    end else begin
      lowPower_reg <= (state_reg == adc_seq_pkg::ST_PDOWN);
      oscRun_reg   <= (state_reg != adc_seq_pkg::ST_PDOWN);
    end
  end

  // Line drivers follow chip select
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      readyOe_reg <= 1'b0;
      doutOe_reg  <= 1'b0;
    end else begin
      readyOe_reg <= selected;
      doutOe_reg  <= selected;
    end
  end

  assign phaseCtl       = phaseCtl_reg;
  assign analogLowPower = lowPower_reg;
  assign oscRun         = oscRun_reg;
  assign link.readyN    = readyN_reg;
  assign link.readyOe   = readyOe_reg;
  assign link.dout      = shift_reg[`RESULT_BITS-1];
  assign link.doutOe    = doutOe_reg;
endmodule : adc_sequencer

/* verilog/adc_host_end.sv */
// Host end: AXI4-Lite registers driving the result link
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_host_end #(
  parameter int unsigned SCLK_LOW_CYC = `SCLK_LOW_US * `CORE_MHZ
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  adc_link_if.host         link
);
  adc_seq_pkg::host_state_t  hs_reg;
  logic [31:0]               ctrl_reg;
  logic [`RESULT_BITS-1:0]   result_reg;
  logic [`RESULT_BITS-1:0]   shiftIn_reg;
  logic [4:0]                bitCnt_reg;
  logic [15:0]               lowCnt_reg;
  logic                      armed_reg;
  logic                      valid_reg;
  logic                      sclkOut_reg;
  logic                      sclkOe_reg;
  logic [7:0]                awAddr_reg;
  logic                      awHeld_reg;
  logic [31:0]               wData_reg;
  logic                      wHeld_reg;
  logic                      wordDone;
  logic                      resultRead;
  logic                      doWrite;

  assign doWrite    = awHeld_reg && wHeld_reg && !bvalid;
  assign resultRead = arvalid && arready && araddr == `REG_RESULT;
  assign wordDone   = hs_reg == adc_seq_pkg::HS_CLK_LOW &&
                      lowCnt_reg == 16'(SCLK_LOW_CYC - 1) &&
                      bitCnt_reg == 5'(`RESULT_BITS - 1);

  // Write channel, address and data in either order
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= '0;
      bvalid     <= 1'b0;
      bresp      <= `RESP_OKAY;
      ctrl_reg   <= `CTRL_RESET;
    end else begin
      if (awvalid && awready) begin
        awAddr_reg <= awaddr;
        awHeld_reg <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready) begin
        wData_reg <= wdata;
        wHeld_reg <= 1'b1;
        wready    <= 1'b0;
      end
      if (doWrite) begin
        bvalid <= 1'b1;
        bresp  <= `RESP_SLVERR;
        if (awAddr_reg == `REG_CTRL) begin
          bresp <= `RESP_OKAY;
          if (wstrb[0])
            ctrl_reg[7:0] <= wData_reg[7:0];
        end else if (awAddr_reg == `REG_STATUS ||
                     awAddr_reg == `REG_RESULT) begin
          bresp <= `RESP_OKAY;
        end
      end
      if (bvalid && bready) begin
        bvalid     <= 1'b0;
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        awready    <= 1'b1;
        wready     <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RESP_OKAY;
      case (araddr)
        `REG_CTRL:   rdata <= ctrl_reg;
        `REG_STATUS: rdata <= {30'h0,
                               hs_reg != adc_seq_pkg::HS_IDLE, valid_reg};
        `REG_RESULT: rdata <= {8'h00, result_reg};
        default: begin
          rdata <= '0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Serial word reception over the handshake
  always_ff @(posedge core_clk) begin
    if (!resetn || !ctrl_reg[`CTRL_SELECT]) begin
      hs_reg      <= adc_seq_pkg::HS_IDLE;
      shiftIn_reg <= '0;
      bitCnt_reg  <= '0;
      lowCnt_reg  <= '0;
      armed_reg   <= 1'b0;
      sclkOut_reg <= 1'b1;
      sclkOe_reg  <= 1'b0;
    end else begin
      sclkOe_reg <= 1'b1;
      case (hs_reg)
        adc_seq_pkg::HS_IDLE: begin
          if (!link.readyLine) begin
            shiftIn_reg <= {shiftIn_reg[`RESULT_BITS-2:0], link.doutLine};
            sclkOut_reg <= 1'b0;
            lowCnt_reg  <= '0;
            hs_reg      <= adc_seq_pkg::HS_CLK_LOW;
          end
        end
        adc_seq_pkg::HS_CLK_LOW: begin
          if (lowCnt_reg == 16'(SCLK_LOW_CYC - 1)) begin
            sclkOut_reg <= 1'b1;
            hs_reg      <= adc_seq_pkg::HS_WAIT_HIGH;
            if (wordDone) begin
              bitCnt_reg <= '0;
              armed_reg  <= 1'b1;
            end else begin
              bitCnt_reg <= bitCnt_reg + 5'h1;
            end
          end else begin
            lowCnt_reg <= lowCnt_reg + 16'h1;
          end
        end
        adc_seq_pkg::HS_WAIT_HIGH: begin
          if (link.readyLine)
            hs_reg <= adc_seq_pkg::HS_IDLE;
        end
        default: hs_reg <= adc_seq_pkg::HS_IDLE;
      endcase
    end
  end

  // Result capture; a new word wins over a read clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      result_reg <= '0;
      valid_reg  <= 1'b0;
    end else if (wordDone && armed_reg) begin
      result_reg <= shiftIn_reg;
      valid_reg  <= 1'b1;
    end else if (resultRead) begin
      valid_reg <= 1'b0;
    end
  end

  assign link.csN       = !ctrl_reg[`CTRL_SELECT];
  assign link.powerRunN = ctrl_reg[`CTRL_PDOWN];
  assign link.integSel  = ctrl_reg[`CTRL_SEL_LSB +: 3];
  assign link.sclkOut   = sclkOut_reg;
  assign link.sclkOe    = sclkOe_reg;
endmodule : adc_host_end

/* tb/adc_seq_monitor.sv */
// Assertions on the result link and the analog phase outputs
`timescale 1ns/1ps
module adc_seq_monitor #(
  parameter int unsigned IZERO_TICKS = 20
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       csN,
  input wire logic       powerRunN,
  input wire logic       readyN,
  input wire logic       readyOe,
  input wire logic       dout,
  input wire logic       doutOe,
  input wire logic       sclkOut,
  input wire logic       sclkOe,
  input wire logic       sclkLine,
  input wire logic       readyLine,
  input wire logic [1:0] phaseCtl,
  input wire logic       comparator,
  input wire logic       analogLowPower,
  input wire logic       oscRun
);
  logic [31:0] izCnt;
  // Cycles spent in integrator zero
  always_ff @(posedge core_clk) begin
    if (!resetn || phaseCtl != adc_seq_pkg::PH_IZERO) izCnt <= '0;
    else izCnt <= izCnt + 32'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence sclkRise;
    $rose(sclkLine) && !csN;
  endsequence
  sequence hostPulse;
    $fell(sclkOut) && sclkOe;
  endsequence
  link_release_a: assert property (
    csN |=> !readyOe && !doutOe) else $error("link not released");
  ready_phase_a: assert property (
    !readyN && readyOe |-> phaseCtl == adc_seq_pkg::PH_AZERO)
    else $error("ready low outside auto zero");
  phase_order_a: assert property (
    $changed(phaseCtl) && !analogLowPower && !$past(analogLowPower)
    |-> phaseCtl == 2'($past(phaseCtl) + 2'h1))
    else $error("phase out of order");
  bit_ack_a: assert property (
    sclkRise ##0 readyOe |=> readyN) else $error("ready not raised");
  bit_hold_a: assert property (
    !readyN && readyOe && !$past(readyN) && $past(readyOe)
    |-> $stable(dout)) else $error("data moved while ready low");
  host_pulse_a: assert property (
    hostPulse |-> !readyLine ##0 !sclkOut[*4])
    else $error("bad serial clock pulse");
  power_down_a: assert property (
    powerRunN[*4] |=> analogLowPower && !oscRun)
    else $error("power-down not entered");
  power_run_a: assert property (
    !powerRunN[*8] |=> !analogLowPower && oscRun)
    else $error("not running");
  deint_end_a: assert property (
    phaseCtl == adc_seq_pkg::PH_DEINT && !comparator && !analogLowPower
    |-> ##[1:12] phaseCtl == adc_seq_pkg::PH_IZERO)
    else $error("deintegrate did not end");
  izero_len_a: assert property (
    phaseCtl == adc_seq_pkg::PH_AZERO
    && $past(phaseCtl) == adc_seq_pkg::PH_IZERO && !analogLowPower
    |-> izCnt inside {[IZERO_TICKS * 4 - 4 : IZERO_TICKS * 4 + 4]})
    else $error("integrator zero length wrong");
endmodule : adc_seq_monitor

/* tb/tb_dual_slope_adc_sequencer.sv */
// Bench for the sequencer and its host end over the result link
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module tb_dual_slope_adc_sequencer;
  logic        core_clk;
  logic        resetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [1:0]  phaseCtl;
  logic        comparator;
  logic        analogLowPower;
  logic        oscRun;
  int          badCount;
  int          checkCount;
  int          cycleCount;
  int          expK[$];
  adc_link_if linkIf();
  adc_sequencer #(.TICKS_PER_US(1), .TIMEOUT_TICKS(40), .IZERO_TICKS(20),
    .INTEG_DIV(1000))
    adc_sequencer_inst (.core_clk(core_clk), .resetn(resetn),
    .phaseCtl(phaseCtl), .comparator(comparator),
    .analogLowPower(analogLowPower), .oscRun(oscRun), .link(linkIf));
  adc_host_end #(.SCLK_LOW_CYC(4)) adc_host_end_inst (
    .core_clk(core_clk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .link(linkIf));
  adc_seq_monitor #(.IZERO_TICKS(20)) adc_seq_monitor_inst (
    .core_clk(core_clk), .resetn(resetn), .csN(linkIf.csN),
    .powerRunN(linkIf.powerRunN), .readyN(linkIf.readyN),
    .readyOe(linkIf.readyOe), .dout(linkIf.dout), .doutOe(linkIf.doutOe),
    .sclkOut(linkIf.sclkOut), .sclkOe(linkIf.sclkOe),
    .sclkLine(linkIf.sclkLine), .readyLine(linkIf.readyLine),
    .phaseCtl(phaseCtl), .comparator(comparator),
    .analogLowPower(analogLowPower), .oscRun(oscRun));
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;
  task wrap_up;
    if (badCount == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // Hang guard
  always @(posedge core_clk) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      badCount++;
      wrap_up();
    end
  end
  task chk(input string name, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task axiWrite(input logic [7:0] a, input logic [31:0] d,
                output logic [1:0] r);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : axiWrite
  task axiRead(input logic [7:0] a, output logic [31:0] d,
               output logic [1:0] r);
    @(posedge core_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask : axiRead
  task waitPhase(input logic [1:0] p);
    while (phaseCtl !== p) @(posedge core_clk);
  endtask : waitPhase
  // Comparator through one conversion, zero crossing k ticks in
  task convert(input logic s, input int k);
    waitPhase(adc_seq_pkg::PH_INTEG);
    comparator <= s;
    waitPhase(adc_seq_pkg::PH_DEINT);
    repeat (4 * k) @(posedge core_clk);
    comparator <= 1'b0;
    waitPhase(adc_seq_pkg::PH_IZERO);
  endtask : convert
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    int          e;
    resetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, comparator} = '0;
    wstrb = 4'hf;
    badCount = 0;
    checkCount = 0;
    cycleCount = 0;
    void'($urandom(32'hb3aa7682));
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    axiRead(`REG_CTRL, d, r);
    chk("ctrl reset", d, `CTRL_RESET);
    chk("default select", {29'h0, linkIf.integSel}, 32'h4);
    axiRead(8'h0c, d, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    chk("unmapped rdata", d, 32'h0);
    axiWrite(8'h0c, 32'hffffffff, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    for (int i = 7; i >= 0; i--) begin
      axiWrite(`REG_CTRL, 32'h2 | (i << 2), r);
      chk("select pins", {29'h0, linkIf.integSel}, i);
    end
    axiWrite(`REG_CTRL, 32'h3, r);
    repeat (10) @(posedge core_clk);
    chk("low power", {31'h0, analogLowPower}, 32'h1);
    chk("osc stopped", {31'h0, oscRun}, 32'h0);
    axiWrite(`REG_CTRL, 32'h0, r);
    repeat (10) @(posedge core_clk);
    chk("osc running", {31'h0, oscRun}, 32'h1);
    chk("phase", {30'h0, phaseCtl}, {30'h0, adc_seq_pkg::PH_AZERO});
    chk("ready released", {31'h0, linkIf.readyLine}, 32'h1);
    chk("ready oe", {31'h0, linkIf.readyOe}, 32'h0);
    chk("data oe", {31'h0, linkIf.doutOe}, 32'h0);
    axiWrite(`REG_CTRL, 32'h2, r);
    k = 5 + ($urandom % 20);
    expK.push_back(k);
    convert(1'b0, 0);
    convert(1'b1, k);
    do axiRead(`REG_STATUS, d, r); while (d[0] !== 1'b1);
    axiRead(`REG_RESULT, d, r);
    e = expK.pop_front();
    chk("sign", {31'h0, d[0]}, 32'h1);
    chk("count", {31'h0, d[23:1] >= e && d[23:1] <= e + 2}, 32'h1);
    axiRead(`REG_STATUS, d, r);
    chk("valid cleared", {31'h0, d[0]}, 32'h0);
    wrap_up();
  end
endmodule : tb_dual_slope_adc_sequencer
